// ---- sfgc_pkg.sv ----
// package: constants and types for the serial filter/gain control register
// Operation
// - one internal 8-bit control register, written over the serial link
// - upper five bits form corner code; zero means no signal, else 1-31 MHz
// - bit 2 preamp gain, bit 1 postamp gain, bit 0 max gain select
// - low three bits together form a 3-bit digital gain code
// - one register value drives both channels identically
// - chip enable low fully disables the device; high operates
// - frame select low starts cycle; first rising edge data picks write or read
// - write captures eight bits on next eight rising edges, lsb first
// - frame select high ends write and applies the captured codes only if all eight bits came in
// - read shifts stored code out on eight falling edges, lsb first
package sfgc_pkg;
  localparam int unsigned sfgc_reg_width = 8;
  localparam int unsigned sfgc_freq_lsb = 3;
  localparam int unsigned sfgc_freq_width = 5;
  localparam int unsigned sfgc_pre_gain_pos = 2;
  localparam int unsigned sfgc_post_gain_pos = 1;
  localparam int unsigned sfgc_max_gain_pos = 0;
  localparam int unsigned sfgc_gain_width = 3;
  localparam logic [7:0] sfgc_reg_reset = 8'h00;
  localparam logic [3:0] sfgc_bit_count_full = 4'h8;
  localparam logic [4:0] sfgc_freq_no_signal = 5'h00;

  typedef enum logic [3:0] {
    sfgc_st_idle = 4'b0001,
    sfgc_st_cmd = 4'b0010,
    sfgc_st_write = 4'b0100,
    sfgc_st_read = 4'b1000
  } sfgc_state_type;
endpackage : sfgc_pkg

// ---- sfgc_pin_if.sv ----
// interface: synchronised link levels and edge pulses
`timescale 1ns/100ps
interface sfgc_pin_if;
  logic frame_active;
  logic frame_end;
  logic clk_rise;
  logic clk_fall;
  logic data_bit;
  modport source (output frame_active, output frame_end, output clk_rise, output clk_fall, output data_bit);
  modport sink (input frame_active, input frame_end, input clk_rise, input clk_fall, input data_bit);
endinterface : sfgc_pin_if

// ---- sfgc_pin_sync.sv ----
// module: two-flop synchronisers and edge detection for the serial pins
`timescale 1ns/100ps
module sfgc_pin_sync (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic frame_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  sfgc_pin_if.source pins
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic sclk_prev_q;
  logic frame_prev_q;

  // first stage feeds only the second stage
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      // reset matches idle pins: frame high, serial clock low, so no false edge
      meta_q <= 3'h5;
      sync_q <= 3'h5;
      sclk_prev_q <= 1'b0;
      frame_prev_q <= 1'b1;
    end else begin
      meta_q <= {frame_select_n_in, serial_clk_in, serial_data_in};
      sync_q <= meta_q;
      sclk_prev_q <= sync_q[1];
      frame_prev_q <= sync_q[2];
    end
  end

  assign pins.frame_active = ~sync_q[2];
  assign pins.frame_end = sync_q[2] & ~frame_prev_q;
  assign pins.clk_rise = sync_q[1] & ~sclk_prev_q;
  assign pins.clk_fall = ~sync_q[1] & sclk_prev_q;
  assign pins.data_bit = sync_q[0];
endmodule : sfgc_pin_sync

// ---- sfgc_top.sv ----
// module: serial programmed filter and gain control register
`timescale 1ns/100ps
module sfgc_top (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic chip_enable_pin_in,
  input wire logic frame_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic device_enabled_out,
  output logic [4:0] freq_code_out,
  output logic freq_no_signal_out,
  output logic pre_gain_bit_out,
  output logic post_gain_bit_out,
  output logic max_gain_bit_out,
  output logic [2:0] digital_gain_code_out
);
  sfgc_pin_if pins ();
  sfgc_pkg::sfgc_state_type state_q;
  sfgc_pkg::sfgc_state_type state_d;
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [3:0] count_q;
  logic [3:0] count_d;
  logic [7:0] out_shift_q;
  logic [7:0] out_shift_d;
  logic sdo_q;
  logic sdo_d;
  logic enable_meta_q;
  logic enable_q;

  sfgc_pin_sync u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .frame_select_n_in(frame_select_n_in),
    .serial_clk_in(serial_clk_in),
    .serial_data_in(serial_data_in),
    .pins(pins)
  );

  // ------------------------------------------------------------
  // chip enable
  // ------------------------------------------------------------
  // pin crosses in through two flops like the serial pins
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      enable_meta_q <= 1'b0;
      enable_q <= 1'b0;
    end else begin
      enable_meta_q <= chip_enable_pin_in;
      enable_q <= enable_meta_q;
    end
  end

  // ------------------------------------------------------------
  // frame qualifiers
  // ------------------------------------------------------------
  // dropping enable mid-frame closes the frame without a commit
  wire frame_go = enable_q & pins.frame_active;
  wire bits_done = (count_q == sfgc_pkg::sfgc_bit_count_full);

  // ------------------------------------------------------------
  // frame sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      sfgc_pkg::sfgc_st_idle: begin
        if (frame_go) begin
          state_d = sfgc_pkg::sfgc_st_cmd;
        end
      end
      sfgc_pkg::sfgc_st_cmd: begin
        if (!frame_go) begin
          state_d = sfgc_pkg::sfgc_st_idle;
        end else if (pins.clk_rise) begin
          state_d = pins.data_bit ? sfgc_pkg::sfgc_st_write : sfgc_pkg::sfgc_st_read;
        end
      end
      sfgc_pkg::sfgc_st_write: begin
        if (!frame_go) begin
          state_d = sfgc_pkg::sfgc_st_idle;
        end
      end
      sfgc_pkg::sfgc_st_read: begin
        if (!frame_go) begin
          state_d = sfgc_pkg::sfgc_st_idle;
        end
      end
      default: begin
        state_d = sfgc_pkg::sfgc_st_idle;
      end
    endcase
  end

  // ------------------------------------------------------------
  // frame events
  // ------------------------------------------------------------
  wire in_cmd = (state_q == sfgc_pkg::sfgc_st_cmd);
  wire in_write = (state_q == sfgc_pkg::sfgc_st_write);
  wire in_read = (state_q == sfgc_pkg::sfgc_st_read);
  wire take_bit = in_write & frame_go & pins.clk_rise & ~bits_done;
  wire send_bit = in_read & frame_go & pins.clk_fall & ~bits_done;
  wire count_step = take_bit | send_bit;
  // commit only on frame end of a complete write; disable also aborts
  wire commit = in_write & pins.frame_end & bits_done & enable_q;
  wire start_cmd = in_cmd & frame_go & pins.clk_rise;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  // counter restarts on the command bit and saturates at eight
  assign count_d = start_cmd ? 4'h0 : (count_step ? count_q + 4'h1 : count_q);
  assign shift_d = take_bit ? {pins.data_bit, shift_q[7:1]} : shift_q;  // lsb arrives first
  // snapshot at the command bit, so a read never sees a half-written value
  assign out_shift_d = start_cmd ? ctrl_q : (send_bit ? {1'b0, out_shift_q[7:1]} : out_shift_q);
  assign sdo_d = send_bit ? out_shift_q[0] : sdo_q;  // lsb leaves first
  // short or aborted writes never commit, so the old value stands
  assign ctrl_d = commit ? shift_q : ctrl_q;

  // ------------------------------------------------------------
  // sequencer state
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_q <= sfgc_pkg::sfgc_st_idle;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // bit counter, shared by write capture and read shift
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      count_q <= 4'h0;
    end else begin
      count_q <= count_d;
    end
  end

  // ------------------------------------------------------------
  // write capture shift register
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      shift_q <= 8'h00;
    end else begin
      shift_q <= shift_d;
    end
  end

  // ------------------------------------------------------------
  // read-back shift register
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      out_shift_q <= 8'h00;
    end else begin
      out_shift_q <= out_shift_d;
    end
  end

  // ------------------------------------------------------------
  // serial data out flop
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      sdo_q <= 1'b0;
    end else begin
      sdo_q <= sdo_d;
    end
  end

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ctrl_q <= sfgc_pkg::sfgc_reg_reset;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // decoded controls, shared by both channels
  // ------------------------------------------------------------
  // single set of outputs, no per-channel copy
  // disabled device drives zero codes and gain bits with the no-signal flag set, but keeps the stored code
  wire [4:0] freq_field = ctrl_q[sfgc_pkg::sfgc_freq_lsb +: sfgc_pkg::sfgc_freq_width];
  wire pre_field = ctrl_q[sfgc_pkg::sfgc_pre_gain_pos];
  wire post_field = ctrl_q[sfgc_pkg::sfgc_post_gain_pos];
  wire max_field = ctrl_q[sfgc_pkg::sfgc_max_gain_pos];
  wire [2:0] gain_field = ctrl_q[sfgc_pkg::sfgc_gain_width-1:0];
  assign device_enabled_out = enable_q;
  assign freq_code_out = enable_q ? freq_field : sfgc_pkg::sfgc_freq_no_signal;
  assign freq_no_signal_out = (freq_code_out == sfgc_pkg::sfgc_freq_no_signal);
  assign pre_gain_bit_out = enable_q & pre_field;
  assign post_gain_bit_out = enable_q & post_field;
  assign max_gain_bit_out = enable_q & max_field;
  assign digital_gain_code_out = enable_q ? gain_field : 3'h0;

  // ------------------------------------------------------------
  // serial data output
  // ------------------------------------------------------------
  assign serial_data_out = sdo_q;
  // pin is only driven while a read frame is open
  assign serial_data_oe_out = in_read & frame_go;
endmodule : sfgc_top

// ---- sfgc_assertions.sv ----
// checker: port-level properties of the serial control register
`timescale 1ns/100ps
module sfgc_assertions (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic chip_enable_pin_in,
  input wire logic frame_select_n_in,
  input wire logic serial_clk_in,
  input wire logic serial_data_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_out,
  input wire logic device_enabled_out,
  input wire logic [4:0] freq_code_out,
  input wire logic freq_no_signal_out,
  input wire logic pre_gain_bit_out,
  input wire logic post_gain_bit_out,
  input wire logic max_gain_bit_out,
  input wire logic [2:0] digital_gain_code_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  no_signal_a: assert property (freq_no_signal_out == (freq_code_out == 5'h00)) else $error("flag");
  gain_code_a: assert property (digital_gain_code_out == {pre_gain_bit_out, post_gain_bit_out, max_gain_bit_out})
    else $error("gain");
  off_zero_a: assert property (!device_enabled_out |-> freq_code_out == 5'h00 && digital_gain_code_out == 3'h0)
    else $error("off");
  off_idle_a: assert property (!chip_enable_pin_in [*4] |-> !device_enabled_out && !serial_data_oe_out)
    else $error("idle");
  // the corner code output may only move once the frame has closed
  commit_gate_a: assert property ($stable(device_enabled_out) && $changed(freq_code_out) |-> frame_select_n_in)
    else $error("commit");
  fs_idle_a: assert property (frame_select_n_in [*8] |-> !serial_data_oe_out) else $error("oe");
  read_start_a: assert property ($rose(serial_data_oe_out) |-> !frame_select_n_in && device_enabled_out)
    else $error("start");
  sdo_hold_a: assert property ($changed(serial_data_out) |-> serial_data_oe_out) else $error("sdo");
  read_c: cover property ($rose(serial_data_oe_out));
  commit_c: cover property ($changed(freq_code_out) && frame_select_n_in);
  disable_c: cover property ($fell(device_enabled_out));
endmodule : sfgc_assertions
bind sfgc_top sfgc_assertions u_chk (.*);

// ---- sfgc_host_model.sv ----
// model: host serial master driving the programming pins
`timescale 1ns/100ps
module sfgc_host_model (
  input wire logic clock_in,
  input wire logic sdo_in,
  output logic fs_n_out,
  output logic sclk_out,
  output logic sdi_out
);
  initial begin
    fs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // serial clock stands low outside frames; data changes on the falling edge
  task automatic frame(input logic wr, input logic [9:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    @(posedge clock_in) #1;
    fs_n_out = 1'b0;
    for (int i = 0; i <= n; i++) begin
      sdi_out = (i == 0) ? wr : d[i - 1];
      #80;
      if (i > 0 && !wr) q[i - 1] = sdo_in;
      sclk_out = 1'b1;
      #80;
      sclk_out = 1'b0;
    end
    #80;
    if (!wr) q[n - 1] = sdo_in;
    fs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #160;
  endtask : frame
endmodule : sfgc_host_model

// ---- testbench.sv ----
// testbench: serial programming and read-back of the control register
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t %h %h", $time, a, b); end end
module testbench;
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic chip_enable_pin_in = 1'b0;
  logic fs_n, sclk, sdi, sdo, oe, en, nosig, pre, post, maxg;
  logic [4:0] freq;
  logic [2:0] dgain;
  logic [7:0] rd, cur, v;
  logic [21:0] exp_q[$];
  logic [21:0] exp_v;
  int err_count = 0;
  int num_checks = 0;
  event done_ev;
  always #4 clock_in = ~clock_in;
  // an undriven data-out pin reads inverted, so a missing output enable shows up
  sfgc_host_model u_host (.clock_in(clock_in), .sdo_in(oe ? sdo : ~sdo), .fs_n_out(fs_n),
    .sclk_out(sclk), .sdi_out(sdi));
  sfgc_top u_dut (.clock_in(clock_in), .reset_in(reset_in), .chip_enable_pin_in(chip_enable_pin_in),
    .frame_select_n_in(fs_n), .serial_clk_in(sclk), .serial_data_in(sdi), .serial_data_out(sdo),
    .serial_data_oe_out(oe), .device_enabled_out(en), .freq_code_out(freq), .freq_no_signal_out(nosig),
    .pre_gain_bit_out(pre), .post_gain_bit_out(post), .max_gain_bit_out(maxg), .digital_gain_code_out(dgain));
  task automatic test_done;
    if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  task automatic note(input logic [21:0] e);
    exp_q.push_back(e);
    ->done_ev;
    @(posedge clock_in) #1;
  endtask : note
  task automatic check_read(input logic [7:0] e);
    u_host.frame(1'b0, 10'h000, 8, rd);
    note({2'b10, e[7:3], e[2:0], e[2:0], e[7:3] == 5'h00, e});
  endtask : check_read
  always @(done_ev) begin
    exp_v = exp_q.pop_front();
    `CHK({en, oe, freq, dgain, pre, post, maxg, nosig, rd}, exp_v)
  end
  initial begin
    v = 8'($urandom(61347));
    repeat (20) @(posedge clock_in);
    #1 reset_in = 1'b0;
    chip_enable_pin_in = 1'b1;
    repeat (4) @(posedge clock_in);
    cur = 8'h00;
    check_read(cur);
    // every corner code, zero included, with random gain bits
    for (int k = 0; k < 32; k++) begin
      v = {k[4:0], 3'($urandom)};
      u_host.frame(1'b1, {2'h0, v}, 8, rd);
      cur = v;
      check_read(cur);
    end
    u_host.frame(1'b1, 10'h0ff, 5, rd);
    check_read(cur);
    v = 8'($urandom);
    u_host.frame(1'b1, {2'h3, v}, 10, rd);
    cur = v;
    check_read(cur);
    chip_enable_pin_in = 1'b0;
    u_host.frame(1'b1, 10'h0aa, 8, rd);
    note({2'b00, 11'h000, 1'b1, 8'h00});
    chip_enable_pin_in = 1'b1;
    repeat (4) @(posedge clock_in);
    check_read(cur);
    test_done();
  end
endmodule : testbench
